// >>> hdl/fram_spi_pkg.sv
// shared constants, types and decoding for the serial memory command engine
package fram_spi_pkg;

    // ----------------------------------------------------------------
    // widths
    // ----------------------------------------------------------------
    localparam int ADDR_W = 18;
    localparam int BYTE_W = 8;

    // ----------------------------------------------------------------
    // op-codes
    // ----------------------------------------------------------------
    localparam logic [7:0] OP_SET_LATCH = 8'h06;
    localparam logic [7:0] OP_CLR_LATCH = 8'h04;
    localparam logic [7:0] OP_STATUS_RD = 8'h05;
    localparam logic [7:0] OP_STATUS_WR = 8'h01;
    localparam logic [7:0] OP_MEM_RD = 8'h03;
    localparam logic [7:0] OP_MEM_WR = 8'h02;

    // ----------------------------------------------------------------
    // status byte layout
    // ----------------------------------------------------------------
    localparam int ST_GUARD_EN_BIT = 7;
    localparam int ST_BLOCK_HI_BIT = 3;
    localparam int ST_BLOCK_LO_BIT = 2;
    localparam int ST_LATCH_BIT = 1;
    localparam logic [7:0] ST_FIXED = 8'h40;
    localparam logic [1:0] BG_RESET = 2'h0;

    // ----------------------------------------------------------------
    // protected ranges
    // ----------------------------------------------------------------
    localparam logic [1:0] BG_NONE = 2'h0;
    localparam logic [1:0] BG_QUARTER = 2'h1;
    localparam logic [1:0] BG_HALF = 2'h2;
    localparam logic [1:0] BG_ALL = 2'h3;
    localparam logic [17:0] PROT_QUARTER_BASE = 18'h3_0000;
    localparam logic [17:0] PROT_HALF_BASE = 18'h2_0000;

    // ----------------------------------------------------------------
    // framing
    // ----------------------------------------------------------------
    localparam logic [2:0] BIT_LAST = 3'h7;
    localparam logic [1:0] ADDR_BYTE_LAST = 2'h2;

    typedef enum logic [2:0] {
        PH_OPCODE = 3'b000,
        PH_STATUS_WR = 3'b001,
        PH_STATUS_RD = 3'b010,
        PH_ADDR = 3'b011,
        PH_DATA = 3'b100,
        PH_IGNORE = 3'b101
    } phase_e;

    typedef struct packed {
        logic guard_en;
        logic [1:0] block_guard;
        logic latch;
    } status_s;

    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [BYTE_W-1:0] data;
    } mem_wr_s;

    function automatic logic [7:0] status_byte(input status_s s);
        logic [7:0] b;
        b = ST_FIXED;
        b[ST_GUARD_EN_BIT] = s.guard_en;
        b[ST_BLOCK_HI_BIT] = s.block_guard[1];
        b[ST_BLOCK_LO_BIT] = s.block_guard[0];
        b[ST_LATCH_BIT] = s.latch;
        return b;
    endfunction

    function automatic logic guarded(input logic [ADDR_W-1:0] addr,
                                     input logic [1:0] bg);
        logic g;
        g = 1'b0;
        unique case (bg)
            BG_NONE: g = 1'b0;
            BG_QUARTER: g = (addr >= PROT_QUARTER_BASE);
            BG_HALF: g = (addr >= PROT_HALF_BASE);
            BG_ALL: g = 1'b1;
        endcase
        return g;
    endfunction

endpackage

// >>> hdl/serial_fram_spi_command_protect.sv
// serial memory command engine: framing, op-codes, write latch, protection
`timescale 1ns/1ns
`default_nettype none

// Function
// RL1: all link traffic moves in 8-bit bytes, most significant bit first
// RL2: input sampled on clock rise, output changed on clock fall
// RL3: master waits one millisecond after power before first select
// RL4: op-codes 06h set latch, 04h clear latch, 05h read status
// RL5: op-codes 01h write status, 03h read memory, 02h write memory; here 03h is ignored, no memory read
// RL6: latch clear at power-up; no write lands before set-latch op-code
// RL7: latch cleared by 04h and at select rise ending 04h, 01h, 02h
// RL8: status write never changes latch flag; only set-latch sets it
// RL9: after status read op-code, shift out one status byte
// RL10: status bits 0, 4, 5 read zero, bit 6 reads one, unwritable
// RL11: status bit 7 guard enable, bits 3:2 block guard, bit 1 latch
// RL12: block guard bits survive power cycles
// RL13: block guard selects protected upper quarter, half, all or none
// RL14: status write blocked when guard enable set and protect pin low
// RL15: protect pin has no effect on memory writes
// RL16: with latch clear, memory and status writes are all rejected
// RL17: write op-code, three address bytes, top six address bits ignored
// RL18: address increments per data byte, wrapping at top to zero
// RL19: each data byte written right after its eighth clock, no limit
// RL20: memory write command ends at select rise
// RL21: protect pin captured at select fall, held for whole command
// RL22: master holds protect pin high and sets latch before status write
// RL23: one op-code per select; later bytes never decode as op-codes
// RL24: modes 0 and 3, chosen by clock level at select fall
// RL25: with select high, clock and input ignored, output released
// RL26: byte to protected address dropped, address still advances
module serial_fram_spi_command_protect #(
    parameter int ADDR_W = fram_spi_pkg::ADDR_W,
    parameter logic [1:0] BLOCK_GUARD_INIT = fram_spi_pkg::BG_RESET
) (
    // system clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // serial link
    input wire logic sclk,
    input wire logic cs_n,
    input wire logic si,
    input wire logic wp_n,
    output logic so,
    output logic so_oe,
    // observation
    output logic mode3,
    input wire logic [ADDR_W-1:0] peek_addr,
    output logic [7:0] peek_data
);

    generate
        if (ADDR_W != fram_spi_pkg::ADDR_W) begin : g_bad_width
            $error("address width must match protected range layout");
        end
    endgenerate

    // ----------------------------------------------------------------
    // link side: framing and shift-in
    // ----------------------------------------------------------------
    logic frame_rst_n;
    logic [7:0] in_sr_q;
    logic [2:0] bit_idx_q;
    logic [7:0] byte_in;
    logic byte_done;
    fram_spi_pkg::phase_e phase_q;
    logic [1:0] addr_cnt_q;
    logic [ADDR_W-1:0] addr_q;
    logic rd_q;
    logic [7:0] out_sr_q;
    logic cmd_tgl_q;
    logic [7:0] cmd_byte_q;
    logic st_tgl_q;
    logic [7:0] st_data_q;
    logic wr_tgl_q;
    fram_spi_pkg::mem_wr_s wr_q;
    fram_spi_pkg::status_s st_s1_q;
    fram_spi_pkg::status_s st_s2_q;
    fram_spi_pkg::status_s status_now;

    // select high holds the whole frame in reset
    assign frame_rst_n = rst_n & ~cs_n;
    assign byte_in = {in_sr_q[6:0], si};
    assign byte_done = (bit_idx_q == fram_spi_pkg::BIT_LAST);

    always_ff @(posedge sclk or negedge frame_rst_n) begin
        if (!frame_rst_n) begin
            in_sr_q <= 8'h00; // [RL25]
            bit_idx_q <= 3'h0;
        end else begin
            in_sr_q <= byte_in; // [RL1] [RL2]
            bit_idx_q <= bit_idx_q + 3'h1;
        end
    end

    always_ff @(posedge sclk or negedge frame_rst_n) begin
        if (!frame_rst_n) begin
            phase_q <= fram_spi_pkg::PH_OPCODE;
            addr_cnt_q <= 2'h0;
        end else if (byte_done) begin
            unique case (phase_q)
                fram_spi_pkg::PH_OPCODE: begin
                    if (byte_in == fram_spi_pkg::OP_STATUS_WR) begin
                        phase_q <= fram_spi_pkg::PH_STATUS_WR; // [RL5]
                    end else if (byte_in == fram_spi_pkg::OP_STATUS_RD) begin
                        phase_q <= fram_spi_pkg::PH_STATUS_RD; // [RL4]
                    end else if (byte_in == fram_spi_pkg::OP_MEM_WR) begin
                        phase_q <= fram_spi_pkg::PH_ADDR; // [RL5] [RL17]
                    end else begin
                        phase_q <= fram_spi_pkg::PH_IGNORE; // [RL23]
                    end
                end
                fram_spi_pkg::PH_ADDR: begin
                    addr_cnt_q <= addr_cnt_q + 2'h1;
                    if (addr_cnt_q == fram_spi_pkg::ADDR_BYTE_LAST) begin
                        phase_q <= fram_spi_pkg::PH_DATA;
                    end
                end
                fram_spi_pkg::PH_STATUS_WR: begin
                    phase_q <= fram_spi_pkg::PH_IGNORE;
                end
                fram_spi_pkg::PH_STATUS_RD,
                fram_spi_pkg::PH_DATA,
                fram_spi_pkg::PH_IGNORE: begin
                    phase_q <= phase_q; // [RL23]
                end
                default: begin
                    phase_q <= fram_spi_pkg::PH_IGNORE;
                end
            endcase
        end
    end

    // address assembly and post-increment
    always_ff @(posedge sclk or negedge frame_rst_n) begin
        if (!frame_rst_n) begin
            addr_q <= '0;
        end else if (byte_done) begin
            if (phase_q == fram_spi_pkg::PH_ADDR) begin
                // top bits of the first address byte fall off the end
                addr_q <= {addr_q[ADDR_W-9:0], byte_in}; // [RL17]
            end else if (phase_q == fram_spi_pkg::PH_DATA) begin
                addr_q <= addr_q + 1'b1; // [RL18] [RL26]
            end
        end
    end

    // ----------------------------------------------------------------
    // link side: events toward the system clock
    // ----------------------------------------------------------------
    // not reset by select: the system side reads them after select rises
    always_ff @(posedge sclk or negedge rst_n) begin
        if (!rst_n) begin
            cmd_tgl_q <= 1'b0;
            cmd_byte_q <= 8'h00;
            st_tgl_q <= 1'b0;
            st_data_q <= 8'h00;
            wr_tgl_q <= 1'b0;
            wr_q <= '0;
        end else if (byte_done) begin
            if (phase_q == fram_spi_pkg::PH_OPCODE) begin
                cmd_tgl_q <= ~cmd_tgl_q; // [RL4] [RL5]
                cmd_byte_q <= byte_in;
            end
            if (phase_q == fram_spi_pkg::PH_STATUS_WR) begin
                st_tgl_q <= ~st_tgl_q;
                st_data_q <= byte_in;
            end
            if (phase_q == fram_spi_pkg::PH_DATA) begin
                wr_tgl_q <= ~wr_tgl_q; // [RL19]
                wr_q.addr <= addr_q;
                wr_q.data <= byte_in;
            end
        end
    end

    // ----------------------------------------------------------------
    // link side: status read-out
    // ----------------------------------------------------------------
    always_ff @(posedge sclk or negedge rst_n) begin
        if (!rst_n) begin
            st_s1_q <= '0;
            st_s2_q <= '0;
        end else begin
            st_s1_q <= status_now;
            st_s2_q <= st_s1_q;
        end
    end

    always_ff @(posedge sclk or negedge frame_rst_n) begin
        if (!frame_rst_n) begin
            rd_q <= 1'b0;
            out_sr_q <= 8'h00;
        end else if (byte_done && phase_q == fram_spi_pkg::PH_OPCODE &&
                     byte_in == fram_spi_pkg::OP_STATUS_RD) begin
            rd_q <= 1'b1;
            out_sr_q <= fram_spi_pkg::status_byte(st_s2_q); // [RL9] [RL10]
        end
    end

    always_ff @(negedge sclk or negedge frame_rst_n) begin
        if (!frame_rst_n) begin
            so <= 1'b0;
            so_oe <= 1'b0; // [RL25]
        end else begin
            so_oe <= rd_q;
            so <= out_sr_q[fram_spi_pkg::BIT_LAST - bit_idx_q]; // [RL2]
        end
    end

    // ----------------------------------------------------------------
    // system side: synchronisers
    // ----------------------------------------------------------------
    logic [3:0] cs_s_q;
    logic [1:0] wp_s_q;
    logic [2:0] sclk_s_q;
    logic [2:0] cmd_s_q;
    logic [2:0] st_s_q;
    logic [2:0] wr_s_q;
    logic cs_rise;
    logic cs_fall;
    logic cmd_evt;
    logic st_evt;
    logic wr_evt;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cs_s_q <= 4'hf;
            wp_s_q <= 2'h3;
            sclk_s_q <= 3'h0;
            cmd_s_q <= 3'h0;
            st_s_q <= 3'h0;
            wr_s_q <= 3'h0;
        end else begin
            cs_s_q <= {cs_s_q[2:0], cs_n};
            wp_s_q <= {wp_s_q[0], wp_n};
            sclk_s_q <= {sclk_s_q[1:0], sclk};
            cmd_s_q <= {cmd_s_q[1:0], cmd_tgl_q};
            st_s_q <= {st_s_q[1:0], st_tgl_q};
            wr_s_q <= {wr_s_q[1:0], wr_tgl_q};
        end
    end

    // select edges run one stage later so that the last event lands first
    assign cs_rise = cs_s_q[2] & ~cs_s_q[3];
    assign cs_fall = ~cs_s_q[2] & cs_s_q[3];
    assign cmd_evt = cmd_s_q[1] ^ cmd_s_q[2];
    assign st_evt = st_s_q[1] ^ st_s_q[2];
    assign wr_evt = wr_s_q[1] ^ wr_s_q[2];

    // ----------------------------------------------------------------
    // system side: pin capture at select fall
    // ----------------------------------------------------------------
    logic wp_cap_q;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wp_cap_q <= 1'b1;
            mode3 <= 1'b0;
        end else if (cs_fall) begin
            wp_cap_q <= wp_s_q[1]; // [RL21]
            mode3 <= sclk_s_q[2]; // [RL24]
        end
    end

    // ----------------------------------------------------------------
    // system side: write latch
    // ----------------------------------------------------------------
    logic latch_q;
    logic arm_q;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            latch_q <= 1'b0; // [RL6]
            arm_q <= 1'b0;
        end else begin
            if (cs_rise) begin
                arm_q <= 1'b0;
                if (arm_q) begin
                    latch_q <= 1'b0; // [RL7] [RL20]
                end
            end
            if (cmd_evt) begin
                if (cmd_byte_q == fram_spi_pkg::OP_CLR_LATCH) begin
                    latch_q <= 1'b0; // [RL7]
                end
                if (cmd_byte_q == fram_spi_pkg::OP_CLR_LATCH ||
                    cmd_byte_q == fram_spi_pkg::OP_STATUS_WR ||
                    cmd_byte_q == fram_spi_pkg::OP_MEM_WR) begin
                    arm_q <= 1'b1; // [RL7]
                end
                if (cmd_byte_q == fram_spi_pkg::OP_SET_LATCH) begin
                    latch_q <= 1'b1; // [RL4] [RL8]
                end
            end
        end
    end

    // ----------------------------------------------------------------
    // system side: status register
    // ----------------------------------------------------------------
    logic guard_en_q;
    logic [1:0] block_guard_q;
    logic st_ok;

    assign st_ok = st_evt && latch_q && !(guard_en_q && !wp_cap_q);
    assign status_now = {guard_en_q, block_guard_q, latch_q}; // [RL11]

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            guard_en_q <= 1'b0;
        end else if (st_ok) begin
            guard_en_q <= st_data_q[fram_spi_pkg::ST_GUARD_EN_BIT]; // [RL14]
        end
    end

    // kept through reset: stands for the nonvolatile cells
    initial block_guard_q = BLOCK_GUARD_INIT;
    always @(posedge clk) begin
        if (st_ok) begin
            block_guard_q <= {st_data_q[fram_spi_pkg::ST_BLOCK_HI_BIT],
                              st_data_q[fram_spi_pkg::ST_BLOCK_LO_BIT]}; // [RL12]
        end
    end

    // ----------------------------------------------------------------
    // system side: memory array
    // ----------------------------------------------------------------
    logic [7:0] mem_q [0:(1<<ADDR_W)-1];
    logic mem_we;

    // protect pin deliberately absent from this term
    assign mem_we = wr_evt && latch_q &&
                    !fram_spi_pkg::guarded(wr_q.addr, block_guard_q); // [RL13] [RL15] [RL16] [RL26]

    always_ff @(posedge clk) begin
        if (mem_we) begin
            mem_q[wr_q.addr] <= wr_q.data; // [RL19]
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            peek_data <= 8'h00;
        end else begin
            peek_data <= mem_q[peek_addr];
        end
    end

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_n);

    a_set_latch_op: assert property ( // [RL4]
        cmd_evt && cmd_byte_q == fram_spi_pkg::OP_SET_LATCH |=> latch_q)
        else $error("set op-code did not raise latch");
    a_clear_latch_op: assert property ( // [RL7]
        cmd_evt && cmd_byte_q == fram_spi_pkg::OP_CLR_LATCH |=> !latch_q)
        else $error("clear op-code left latch set");
    a_select_end_clear: assert property ( // [RL7]
        cs_rise && arm_q && !cmd_evt |=> !latch_q && !arm_q)
        else $error("latch survived end of write command");
    a_status_pin_block: assert property ( // [RL14]
        st_evt && guard_en_q && !wp_cap_q |=> $stable(block_guard_q)
        && $stable(guard_en_q))
        else $error("status write passed a low protect pin");
    a_latch_gate_status: assert property ( // [RL16]
        st_evt && !latch_q |=> $stable(block_guard_q) && $stable(guard_en_q))
        else $error("status write without latch");
    a_status_accept: assert property ( // [RL11]
        st_evt && latch_q && (!guard_en_q || wp_cap_q) |=>
        block_guard_q == {$past(st_data_q[3]), $past(st_data_q[2])})
        else $error("accepted status write not stored");
    a_status_keeps_latch: assert property ( // [RL8]
        st_evt && !cmd_evt && !cs_rise |=> latch_q == $past(latch_q))
        else $error("status write moved latch");
    a_guarded_no_write: assert property ( // [RL13]
        mem_we |-> latch_q && (block_guard_q == fram_spi_pkg::BG_NONE ||
        {block_guard_q, wr_q.addr[17:16]} inside {4'h4,4'h5,4'h6,4'h8,4'h9}))
        else $error("write into protected range");
    a_mem_store: assert property ( // [RL19]
        mem_we ##1 wr_q.addr == peek_addr |=> peek_data == $past(wr_q.data, 2))
        else $error("accepted byte not found in array");
    a_pin_capture: assert property ( // [RL21]
        cs_fall |=> wp_cap_q == $past(wp_s_q[1]) ##1 $stable(wp_cap_q))
        else $error("protect pin not captured at select fall");

    c_set_latch: cover property (
        cmd_evt && cmd_byte_q == fram_spi_pkg::OP_SET_LATCH);
    c_mem_write: cover property (mem_we ##[1:100] mem_we);
    c_status_ok: cover property (st_ok);
    c_status_blocked: cover property (st_evt && latch_q && !st_ok);

endmodule

`default_nettype wire

// >>> testbench/spi_host_model.sv
// host-side serial master model that drives the memory link
`timescale 1ns/1ns
`default_nettype none
module spi_host_model (
    // serial link
    output logic sclk,
    output logic cs_n,
    output logic si,
    input wire logic so,
    input wire logic so_oe,
    // bytes captured from so
    output logic [7:0] rx_byte,
    output logic rx_stb
);
    initial begin
        sclk = 1'b0;
        cs_n = 1'b1;
        si = 1'b0;
        rx_byte = 8'h00;
        rx_stb = 1'b0;
    end

    // one select frame; the clock idles at m3 and stands still outside it
    task automatic frame(input logic [7:0] tx[$], input logic m3,
                         input logic report);
        logic [7:0] r;
        r = 8'h00;
        sclk = m3;
        #5 cs_n = 1'b0;
        #5;
        foreach (tx[i]) begin
            for (int b = 7; b >= 0; b--) begin
                sclk = 1'b0;
                si = tx[i][b];
                #3 sclk = 1'b1;
                r[b] = so & so_oe;
                #3;
            end
            if (report && i > 0) begin
                rx_byte = r;
                rx_stb = 1'b1;
                #1 rx_stb = 1'b0;
            end
        end
        sclk = m3;
        #3 cs_n = 1'b1;
        si = ~si;
        #40;
    endtask
endmodule
`default_nettype wire

// >>> testbench/serial_fram_spi_command_protect_tb.sv
// self-checking bench for the serial memory command engine
`timescale 1ns/1ns
`default_nettype none
module serial_fram_spi_command_protect_tb;
    logic clk, rst_n, sclk, cs_n, si, wp_n, so, so_oe, mode3, rx_stb;
    logic peek_req, m3, gen;
    logic peek_pend = 1'b0;
    logic [17:0] peek_addr;
    logic [7:0] peek_data, rx_byte;
    logic [1:0] bg;
    logic [7:0] exp_st[$];
    logic [7:0] exp_mem[$];
    logic [7:0] ref_mem[logic [17:0]];
    int mismatches, cmp_count, seed;

    serial_fram_spi_command_protect u_serial_fram_spi_command_protect (
        .clk(clk), .rst_n(rst_n), .sclk(sclk), .cs_n(cs_n), .si(si),
        .wp_n(wp_n), .so(so), .so_oe(so_oe), .mode3(mode3),
        .peek_addr(peek_addr), .peek_data(peek_data));
    spi_host_model u_spi_host_model (
        .sclk(sclk), .cs_n(cs_n), .si(si), .so(so), .so_oe(so_oe),
        .rx_byte(rx_byte), .rx_stb(rx_stb));

    initial clk = 1'b0;
    always #2 clk = ~clk;

    // ----------------------------------------------------------------
    // helpers
    // ----------------------------------------------------------------
    task automatic check(input string what, input logic [7:0] exp,
                         input logic [7:0] got);
        cmp_count++;
        if (got !== exp) begin
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
            mismatches++;
        end
    endtask

    task automatic test_done();
        $display("mismatches %0d comparisons %0d", mismatches, cmp_count);
        if (mismatches == 0 && cmp_count > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    function automatic logic [7:0] stat(input logic lat);
        return {gen, 3'b100, bg, lat, 1'b0};
    endfunction

    function automatic logic prot(input logic [17:0] a);
        case (bg)
            2'd0: return 1'b0;
            2'd1: return a >= 18'h3_0000;
            2'd2: return a >= 18'h2_0000;
            default: return 1'b1;
        endcase
    endfunction

    task automatic run_frame(input logic [7:0] tx[$], input logic rep);
        m3 = ($urandom_range(1) == 1);
        check("so_oe_idle", 8'h00, {7'h00, so_oe});
        u_spi_host_model.frame(tx, m3, rep);
        check("mode3", {7'h00, m3}, {7'h00, mode3});
    endtask

    task automatic op(input logic [7:0] code);
        run_frame('{code}, 1'b0);
    endtask

    // the status byte is repeated, so two reads are noted
    task automatic status_rd(input logic [7:0] exp);
        exp_st.push_back(exp);
        exp_st.push_back(exp);
        run_frame('{fram_spi_pkg::OP_STATUS_RD, 8'h00, 8'h00}, 1'b1);
    endtask

    task automatic status_wr(input logic [7:0] v, input logic ok);
        op(fram_spi_pkg::OP_SET_LATCH);
        run_frame('{fram_spi_pkg::OP_STATUS_WR, v}, 1'b0);
        if (ok) begin
            bg = v[3:2];
            gen = v[7];
        end
    endtask

    task automatic peek(input logic [17:0] a);
        @(negedge clk);
        peek_addr = a;
        peek_req = 1'b1;
        exp_mem.push_back(ref_mem[a]);
        @(negedge clk);
        peek_req = 1'b0;
        @(negedge clk);
    endtask

    // top six address bits are sent as ones and must be ignored
    task automatic mem_wr(input logic [17:0] a, input int n, input logic en);
        logic [7:0] tx[$];
        logic [17:0] p;
        logic [7:0] d;
        tx = '{fram_spi_pkg::OP_MEM_WR, {6'h3f, a[17:16]}, a[15:8], a[7:0]};
        p = a;
        for (int i = 0; i < n; i++) begin
            d = 8'($urandom);
            tx.push_back(d);
            if (en && !prot(p))
                ref_mem[p] = d;
            p = p + 18'h1;
        end
        if (en)
            op(fram_spi_pkg::OP_SET_LATCH);
        run_frame(tx, 1'b0);
        p = a;
        for (int i = 0; i < n; i++) begin
            peek(p);
            p = p + 18'h1;
        end
    endtask

    // ----------------------------------------------------------------
    // result watchers
    // ----------------------------------------------------------------
    always @(posedge rx_stb) begin
        if (exp_st.size() > 0)
            check("status_byte", exp_st.pop_front(), rx_byte);
        else
            check("status_spare", 8'h00, 8'hff);
    end

    always @(posedge clk) begin
        peek_pend <= peek_req;
        if (peek_pend)
            check("peek_data", exp_mem.pop_front(), peek_data);
    end

    // ----------------------------------------------------------------
    // main sequence
    // ----------------------------------------------------------------
    initial begin
        seed = $urandom(32'h0ddc_0203);
        rst_n = 1'b0;
        wp_n = 1'b1;
        peek_addr = 18'h0_0000;
        peek_req = 1'b0;
        bg = 2'b00;
        gen = 1'b0;
        m3 = 1'b0;
        mismatches = 0;
        cmp_count = 0;
        repeat (6) @(negedge clk);
        rst_n = 1'b1;
        repeat (4) @(negedge clk);
        status_rd(stat(1'b0));
        op(fram_spi_pkg::OP_SET_LATCH);
        status_rd(stat(1'b1));
        op(fram_spi_pkg::OP_CLR_LATCH);
        status_rd(stat(1'b0));
        for (int k = 0; k < 4; k++) begin
            status_wr({4'h3, 2'(k), 2'b11}, 1'b1);
            status_rd(stat(1'b0));
            mem_wr(18'h1_ffff, 2, 1'b1);
            mem_wr(18'h2_ffff, 2, 1'b1);
        end
        @(negedge clk);
        rst_n = 1'b0;
        gen = 1'b0;
        repeat (6) @(negedge clk);
        rst_n = 1'b1;
        repeat (4) @(negedge clk);
        status_rd(stat(1'b0));
        status_wr(8'h00, 1'b1);
        mem_wr(18'h1_ffff, 1, 1'b0);
        mem_wr(18'h3_ffff, 2, 1'b1);
        run_frame('{fram_spi_pkg::OP_MEM_RD, fram_spi_pkg::OP_SET_LATCH}, 1'b0);
        status_rd(stat(1'b0));
        run_frame('{fram_spi_pkg::OP_SET_LATCH, 8'h04}, 1'b0);
        status_rd(stat(1'b1));
        op(fram_spi_pkg::OP_CLR_LATCH);
        status_wr(8'h80, 1'b1);
        status_rd(stat(1'b0));
        @(negedge clk);
        wp_n = 1'b0;
        status_wr(8'h8c, 1'b0);
        op(fram_spi_pkg::OP_CLR_LATCH);
        status_rd(stat(1'b0));
        fork
            status_wr(8'h8c, 1'b0);
            begin
                #130;
                @(negedge clk);
                wp_n = 1'b1;
            end
        join
        op(fram_spi_pkg::OP_CLR_LATCH);
        status_rd(stat(1'b0));
        @(negedge clk);
        wp_n = 1'b0;
        mem_wr(18'h0_0100, 3, 1'b1);
        @(negedge clk);
        wp_n = 1'b1;
        status_wr(8'h00, 1'b1);
        @(negedge clk);
        wp_n = 1'b0;
        status_wr(8'h04, 1'b1);
        status_rd(stat(1'b0));
        repeat (4) @(negedge clk);
        test_done();
    end

    initial begin
        #100000;
        mismatches++;
        test_done();
    end
endmodule
`default_nettype wire
